// >>> src/dsd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Program store is addressed by a 12-bit program counter.
// - Six-entry, 12-bit return stack holds call return addresses.
// - Data addresses 40h-7Fh read a 64-byte view of program store.
// - Window address is window base bits above the low 6 address bits.
// - Window sits at any 64-byte step inside program store 000h-FFFh.
// - Window base at C9h takes byte writes only; no reads, no bit ops.
// - Window base counts as 0 after reset until software writes it.
// - Only window base bits 5-0 are kept; bits 6 and 7 ignored.
// - Addresses 00h-3Fh are banked RAM or nonvolatile pages.
// - Sixty bytes of data RAM sit at 84h-BFh.
// - Index registers at 80h-83h, accumulator at FFh.
// - Port data C0h-C2h, direction C4h-C6h, option CCh-CEh decoded.
// - Interrupt option register at C8h is decoded write-only.
// - Timer prescaler, counter, status at D2h, D3h, D4h.
// - Serial data, divider, mode registers at E0h, E1h, E2h.
// - Write-only bank select at E8h; nonvolatile control at EAh.
// - Readout protection blocks every external program store read.
// - Bank select bit 4 extra RAM, bit 1 page 1, bit 0 page 0.
// - Bank select outputs clear on reset; calls and returns leave them unchanged.
module dsd_decoder #(
	parameter logic [11:0] PC_RESET = 12'h000
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_in,
	input  wire logic [7:0]                  addr_in,
	input  wire logic                        rd_in,
	input  wire logic                        wr_in,
	input  wire logic                        bit_op_in,
	input  wire logic [7:0]                  wdata_in,
	input  wire logic [7:0]                  prog_data_in,
	input  wire logic                        pc_inc_in,
	input  wire logic                        pc_load_in,
	input  wire logic [11:0]                 pc_target_in,
	input  wire logic                        call_in,
	input  wire logic                        ret_in,
	input  wire logic                        protect_opt_in,
	input  wire logic                        ext_rd_in,
	input  wire logic [11:0]                 ext_addr_in,
	output logic      [3:0]                  region_out,
	output logic                             acc_rd_out,
	output logic                             acc_wr_out,
	output logic      [5:0]                  acc_index_out,
	output logic      [7:0]                  acc_wdata_out,
	output logic      [11:0]                 prog_win_addr_out,
	output logic                             prog_win_rd_out,
	output logic      [7:0]                  win_rdata_out,
	output logic                             win_rvalid_out,
	output logic                             extra_ram_page_sel_out,
	output logic                             nvm_page1_sel_out,
	output logic                             nvm_page0_sel_out,
	output logic      [11:0]                 pc_out,
	output logic      [11:0]                 ret_addr_out,
	output logic      [2:0]                  stack_depth_out,
	output logic                             prog_ext_rd_out,
	output logic      [11:0]                 prog_ext_addr_out,
	output logic                             ext_blocked_out
);

	function automatic logic in_rng(input logic [7:0] a,
	                                input logic [7:0] lo,
	                                input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic dsd_pkg::dsd_region_t decode_region(
		input logic [7:0] a,
		input logic       wr,
		input logic       bitop);
		dsd_pkg::dsd_region_t r;
		r = dsd_pkg::RGN_NONE;
		if (in_rng(a, dsd_pkg::BANK_LO, dsd_pkg::BANK_HI))
			r = dsd_pkg::RGN_BANK;
		else if (in_rng(a, dsd_pkg::WIN_LO, dsd_pkg::WIN_HI))
			r = wr ? dsd_pkg::RGN_NONE : dsd_pkg::RGN_WINDOW;
		else if (in_rng(a, dsd_pkg::IDX_LO, dsd_pkg::IDX_HI))
			r = dsd_pkg::RGN_CORE_IDX;
		else if (in_rng(a, dsd_pkg::RAM_LO, dsd_pkg::RAM_HI))
			r = dsd_pkg::RGN_RAM;
		else if (in_rng(a, dsd_pkg::PDAT_LO, dsd_pkg::PDAT_HI))
			r = dsd_pkg::RGN_PORT_DAT;
		else if (in_rng(a, dsd_pkg::PDIR_LO, dsd_pkg::PDIR_HI))
			r = dsd_pkg::RGN_PORT_DIR;
		else if (a == dsd_pkg::INT_OPT)
			r = wr ? dsd_pkg::RGN_INT_OPT : dsd_pkg::RGN_NONE;
		else if (a == dsd_pkg::WIN_BASE)
			r = (wr && !bitop) ? dsd_pkg::RGN_WIN_BASE
			                   : dsd_pkg::RGN_NONE;
		else if (in_rng(a, dsd_pkg::POPT_LO, dsd_pkg::POPT_HI))
			r = dsd_pkg::RGN_PORT_OPT;
		else if (in_rng(a, dsd_pkg::TIM_LO, dsd_pkg::TIM_HI))
			r = dsd_pkg::RGN_TIMER;
		else if (in_rng(a, dsd_pkg::SPI_LO, dsd_pkg::SPI_HI))
			r = dsd_pkg::RGN_SPI;
		else if (a == dsd_pkg::BANK_SEL)
			r = (wr && !bitop) ? dsd_pkg::RGN_BANK_SEL
			                   : dsd_pkg::RGN_NONE;
		else if (a == dsd_pkg::NVM_CTL)
			r = dsd_pkg::RGN_NVM_CTL;
		else if (a == dsd_pkg::ACCUM)
			r = dsd_pkg::RGN_ACCUM;
		return r;
	endfunction

	function automatic logic [5:0] local_index(
		input logic [7:0]           a,
		input dsd_pkg::dsd_region_t r);
		logic [7:0] base;
		base = '0;
		unique case (r)
			dsd_pkg::RGN_CORE_IDX: base = dsd_pkg::IDX_LO;
			dsd_pkg::RGN_RAM:      base = dsd_pkg::RAM_LO;
			dsd_pkg::RGN_PORT_DAT: base = dsd_pkg::PDAT_LO;
			dsd_pkg::RGN_PORT_DIR: base = dsd_pkg::PDIR_LO;
			dsd_pkg::RGN_PORT_OPT: base = dsd_pkg::POPT_LO;
			dsd_pkg::RGN_TIMER:    base = dsd_pkg::TIM_LO;
			dsd_pkg::RGN_SPI:      base = dsd_pkg::SPI_LO;
			dsd_pkg::RGN_NONE,
			dsd_pkg::RGN_BANK,
			dsd_pkg::RGN_WINDOW,
			dsd_pkg::RGN_INT_OPT,
			dsd_pkg::RGN_WIN_BASE,
			dsd_pkg::RGN_BANK_SEL,
			dsd_pkg::RGN_NVM_CTL,
			dsd_pkg::RGN_ACCUM:    base = {2'h0, a[5:0]} & 8'h00;
		endcase
		return (r == dsd_pkg::RGN_BANK || r == dsd_pkg::RGN_WINDOW)
		       ? a[5:0] : 6'(a - base);
	endfunction

	// Core access decode
	dsd_pkg::dsd_region_t rgn_now;
	logic                 wr_eff;
	logic                 rd_eff;
	logic [3:0]           region_reg,    region_next;
	logic                 acc_rd_reg,    acc_rd_next;
	logic                 acc_wr_reg,    acc_wr_next;
	logic [5:0]           acc_index_reg, acc_index_next;
	logic [7:0]           acc_wdata_reg, acc_wdata_next;

	assign wr_eff  = wr_in;
	assign rd_eff  = rd_in && !wr_in;
	assign rgn_now = decode_region(addr_in, wr_eff, bit_op_in);

	always_comb begin
		region_next    = dsd_pkg::RGN_NONE;
		acc_rd_next    = 1'b0;
		acc_wr_next    = 1'b0;
		acc_index_next = '0;
		acc_wdata_next = acc_wdata_reg;
		if ((rd_eff || wr_eff) && rgn_now != dsd_pkg::RGN_NONE) begin
			region_next    = rgn_now;
			acc_rd_next    = rd_eff;
			acc_wr_next    = wr_eff;
			acc_index_next = local_index(addr_in, rgn_now);
			acc_wdata_next = wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			region_reg    <= dsd_pkg::RGN_NONE;
			acc_rd_reg    <= 1'b0;
			acc_wr_reg    <= 1'b0;
			acc_index_reg <= '0;
			acc_wdata_reg <= '0;
		end else begin
			region_reg    <= region_next;
			acc_rd_reg    <= acc_rd_next;
			acc_wr_reg    <= acc_wr_next;
			acc_index_reg <= acc_index_next;
			acc_wdata_reg <= acc_wdata_next;
		end
	end

	// Write-only window base and bank select; contents kept over reset
	logic                 base_wr;
	logic                 bank_wr;
	logic [5:0]           base_reg, base_next;
	logic                 base_ok_reg, base_ok_next;
	logic [7:0]           bank_reg, bank_next;
	logic                 bank_ok_reg, bank_ok_next;

	assign base_wr = wr_eff && rgn_now == dsd_pkg::RGN_WIN_BASE;
	assign bank_wr = wr_eff && rgn_now == dsd_pkg::RGN_BANK_SEL;

	always_comb begin
		base_next    = base_reg;
		base_ok_next = base_ok_reg;
		bank_next    = bank_reg;
		bank_ok_next = bank_ok_reg;
		if (base_wr) begin
			base_next    = wdata_in[dsd_pkg::BASE_W-1:0];
			base_ok_next = 1'b1;
		end
		if (bank_wr) begin
			bank_next    = wdata_in;
			bank_ok_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		base_reg <= base_next;
		bank_reg <= bank_next;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			base_ok_reg <= 1'b0;
			bank_ok_reg <= 1'b0;
		end else begin
			base_ok_reg <= base_ok_next;
			bank_ok_reg <= bank_ok_next;
		end
	end

	// Window read path to the program store
	logic [5:0]           base_used;
	logic [11:0]          win_addr_reg,  win_addr_next;
	logic                 win_rd_reg,    win_rd_next;
	logic [7:0]           win_data_reg,  win_data_next;
	logic                 win_vld_reg,   win_vld_next;
	logic                 xram_reg,      xram_next;
	logic                 nvm1_reg,      nvm1_next;
	logic                 nvm0_reg,      nvm0_next;

	assign base_used = base_ok_reg ? base_reg : '0;

	always_comb begin
		win_addr_next = win_addr_reg;
		win_rd_next   = 1'b0;
		win_data_next = win_data_reg;
		win_vld_next  = 1'b0;
		if (rd_eff && rgn_now == dsd_pkg::RGN_WINDOW) begin
			win_addr_next = {base_used, addr_in[dsd_pkg::OFS_W-1:0]};
			win_rd_next   = 1'b1;
		end
		if (win_rd_reg) begin
			win_data_next = prog_data_in;
			win_vld_next  = 1'b1;
		end
		xram_next = bank_ok_next && bank_next[dsd_pkg::BS_EXTRA_BIT];
		nvm1_next = bank_ok_next && bank_next[dsd_pkg::BS_NVM1_BIT];
		nvm0_next = bank_ok_next && bank_next[dsd_pkg::BS_NVM0_BIT];
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			win_addr_reg <= '0;
			win_rd_reg   <= 1'b0;
			win_data_reg <= '0;
			win_vld_reg  <= 1'b0;
			xram_reg     <= 1'b0;
			nvm1_reg     <= 1'b0;
			nvm0_reg     <= 1'b0;
		end else begin
			win_addr_reg <= win_addr_next;
			win_rd_reg   <= win_rd_next;
			win_data_reg <= win_data_next;
			win_vld_reg  <= win_vld_next;
			xram_reg     <= xram_next;
			nvm1_reg     <= nvm1_next;
			nvm0_reg     <= nvm0_next;
		end
	end

	// Program counter, return stack and external readout
	logic [11:0]          pc_reg,  pc_next;
	logic [11:0]          stack_top;
	logic                 ext_rd_reg,   ext_rd_next;
	logic [11:0]          ext_addr_reg, ext_addr_next;
	logic                 ext_blk_reg,  ext_blk_next;

	always_comb begin
		pc_next = pc_reg;
		if (ret_in)
			pc_next = stack_top;
		else if (call_in || pc_load_in)
			pc_next = pc_target_in;
		else if (pc_inc_in)
			pc_next = pc_reg + dsd_pkg::PC_ONE;
		ext_rd_next   = ext_rd_in && !protect_opt_in;
		ext_blk_next  = ext_rd_in && protect_opt_in;
		ext_addr_next = ext_rd_next ? ext_addr_in : ext_addr_reg;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pc_reg       <= PC_RESET;
			ext_rd_reg   <= 1'b0;
			ext_addr_reg <= '0;
			ext_blk_reg  <= 1'b0;
		end else begin
			pc_reg       <= pc_next;
			ext_rd_reg   <= ext_rd_next;
			ext_addr_reg <= ext_addr_next;
			ext_blk_reg  <= ext_blk_next;
		end
	end

	dsd_return_stack u_stack (
		.clk_sys_in   (clk_sys_in),
		.rst_in       (rst_in),
		.push_in      (call_in && !ret_in),
		.pop_in       (ret_in),
		.push_data_in (pc_reg),
		.top_out      (stack_top),
		.depth_out    (stack_depth_out)
	);

	assign region_out             = region_reg;
	assign acc_rd_out             = acc_rd_reg;
	assign acc_wr_out             = acc_wr_reg;
	assign acc_index_out          = acc_index_reg;
	assign acc_wdata_out          = acc_wdata_reg;
	assign prog_win_addr_out      = win_addr_reg;
	assign prog_win_rd_out        = win_rd_reg;
	assign win_rdata_out          = win_data_reg;
	assign win_rvalid_out         = win_vld_reg;
	assign extra_ram_page_sel_out = xram_reg;
	assign nvm_page1_sel_out      = nvm1_reg;
	assign nvm_page0_sel_out      = nvm0_reg;
	assign pc_out                 = pc_reg;
	assign ret_addr_out           = stack_top;
	assign prog_ext_rd_out        = ext_rd_reg;
	assign prog_ext_addr_out      = ext_addr_reg;
	assign ext_blocked_out        = ext_blk_reg;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	win_addr_a: assert property (
		(rd_eff && in_rng(addr_in, dsd_pkg::WIN_LO, dsd_pkg::WIN_HI)
		 && base_ok_reg) |=> prog_win_rd_out
		&& prog_win_addr_out == {$past(base_reg), $past(addr_in[5:0])})
		else $error("window address wrong");
	win_data_a: assert property (
		prog_win_rd_out |=> win_rvalid_out
		&& win_rdata_out == $past(prog_data_in))
		else $error("window data not returned");
	base_store_a: assert property (
		(wr_in && addr_in == dsd_pkg::WIN_BASE && !bit_op_in)
		|=> base_reg == $past(wdata_in[5:0]) && base_ok_reg)
		else $error("window base not stored");
	base_bitop_a: assert property (
		(wr_in && addr_in == dsd_pkg::WIN_BASE && bit_op_in)
		|=> $stable(base_reg) && region_out == dsd_pkg::RGN_NONE)
		else $error("bit op changed window base");
	bank_sel_a: assert property (
		(wr_in && addr_in == dsd_pkg::BANK_SEL && !bit_op_in)
		|=> extra_ram_page_sel_out == $past(wdata_in[4])
		&& nvm_page1_sel_out == $past(wdata_in[1])
		&& nvm_page0_sel_out == $past(wdata_in[0]))
		else $error("bank select outputs wrong");
	bank_keep_a: assert property (
		!bank_wr ##1 !bank_wr |=> $stable(nvm_page0_sel_out)
		&& $stable(extra_ram_page_sel_out))
		else $error("bank select changed without write");
	ram_rgn_a: assert property (
		(rd_eff && in_rng(addr_in, dsd_pkg::RAM_LO, dsd_pkg::RAM_HI))
		|=> region_out == dsd_pkg::RGN_RAM && acc_rd_out
		&& acc_index_out == 6'($past(addr_in) - dsd_pkg::RAM_LO))
		else $error("data RAM decode wrong");
	protect_a: assert property (
		(ext_rd_in && protect_opt_in) |=> !prog_ext_rd_out
		&& ext_blocked_out)
		else $error("protected readout passed");
	reserved_a: assert property (
		((rd_in || wr_in) && addr_in == 8'hc3) |=> !acc_rd_out
		&& !acc_wr_out && region_out == dsd_pkg::RGN_NONE)
		else $error("reserved address decoded");
	int_opt_a: assert property (
		(rd_eff && addr_in == dsd_pkg::INT_OPT) |=> !acc_rd_out)
		else $error("interrupt option read decoded");
	call_ret_a: assert property (
		(call_in && !ret_in) ##1 (ret_in && !call_in)
		|=> pc_out == $past(pc_out, 2))
		else $error("return address lost");
	pc_inc_a: assert property (
		(pc_inc_in && !pc_load_in && !call_in && !ret_in)
		|=> pc_out == 12'($past(pc_out) + 12'h001))
		else $error("program counter did not step");

	win_read_c: cover property (prog_win_rd_out ##1 win_rvalid_out);
	bank_wr_c:  cover property (bank_wr ##1 nvm_page0_sel_out);
	call_ret_c: cover property (call_in ##[1:4] ret_in);
	blocked_c:  cover property (ext_blocked_out);

endmodule
`default_nettype wire

// >>> src/dsd_pkg.sv
package dsd_pkg;

	localparam int unsigned DATA_W   = 8;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned PC_W     = 12;
	localparam int unsigned OFS_W    = 6;
	localparam int unsigned BASE_W   = 6;
	localparam int unsigned STACK_N  = 6;
	localparam int unsigned DEPTH_W  = 3;

	localparam logic [7:0] BANK_LO   = 8'h00;
	localparam logic [7:0] BANK_HI   = 8'h3f;
	localparam logic [7:0] WIN_LO    = 8'h40;
	localparam logic [7:0] WIN_HI    = 8'h7f;
	localparam logic [7:0] IDX_LO    = 8'h80;
	localparam logic [7:0] IDX_HI    = 8'h83;
	localparam logic [7:0] RAM_LO    = 8'h84;
	localparam logic [7:0] RAM_HI    = 8'hbf;
	localparam logic [7:0] PDAT_LO   = 8'hc0;
	localparam logic [7:0] PDAT_HI   = 8'hc2;
	localparam logic [7:0] PDIR_LO   = 8'hc4;
	localparam logic [7:0] PDIR_HI   = 8'hc6;
	localparam logic [7:0] INT_OPT   = 8'hc8;
	localparam logic [7:0] WIN_BASE  = 8'hc9;
	localparam logic [7:0] POPT_LO   = 8'hcc;
	localparam logic [7:0] POPT_HI   = 8'hce;
	localparam logic [7:0] TIM_LO    = 8'hd2;
	localparam logic [7:0] TIM_HI    = 8'hd4;
	localparam logic [7:0] SPI_LO    = 8'he0;
	localparam logic [7:0] SPI_HI    = 8'he2;
	localparam logic [7:0] BANK_SEL  = 8'he8;
	localparam logic [7:0] NVM_CTL   = 8'hea;
	localparam logic [7:0] ACCUM     = 8'hff;

	localparam int unsigned BS_EXTRA_BIT = 4;
	localparam int unsigned BS_NVM1_BIT  = 1;
	localparam int unsigned BS_NVM0_BIT  = 0;

	localparam logic [11:0] PC_ONE   = 12'h001;

	typedef enum logic [3:0] {
		RGN_NONE     = 4'h0,
		RGN_BANK     = 4'h1,
		RGN_WINDOW   = 4'h2,
		RGN_CORE_IDX = 4'h3,
		RGN_RAM      = 4'h4,
		RGN_PORT_DAT = 4'h5,
		RGN_PORT_DIR = 4'h6,
		RGN_INT_OPT  = 4'h7,
		RGN_WIN_BASE = 4'h8,
		RGN_PORT_OPT = 4'h9,
		RGN_TIMER    = 4'ha,
		RGN_SPI      = 4'hb,
		RGN_BANK_SEL = 4'hc,
		RGN_NVM_CTL  = 4'hd,
		RGN_ACCUM    = 4'he
	} dsd_region_t;

endpackage

// >>> src/dsd_return_stack.sv
`timescale 1ns/10ps
`default_nettype none
module dsd_return_stack #(
	parameter int unsigned WIDTH = dsd_pkg::PC_W,
	parameter int unsigned DEPTH = dsd_pkg::STACK_N
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_in,
	input  wire logic                        push_in,
	input  wire logic                        pop_in,
	input  wire logic [WIDTH-1:0]            push_data_in,
	output logic      [WIDTH-1:0]            top_out,
	output logic      [dsd_pkg::DEPTH_W-1:0] depth_out
);

	logic [WIDTH-1:0]            stack_reg  [DEPTH];
	logic [WIDTH-1:0]            stack_next [DEPTH];
	logic [dsd_pkg::DEPTH_W-1:0] depth_reg;
	logic [dsd_pkg::DEPTH_W-1:0] depth_next;

	// Shift stack; a push on a full stack drops the deepest entry
	always_comb begin
		stack_next = stack_reg;
		depth_next = depth_reg;
		if (push_in) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				stack_next[i] = stack_reg[i-1];
			end
			stack_next[0] = push_data_in;
			if (depth_reg != dsd_pkg::DEPTH_W'(DEPTH)) begin
				depth_next = depth_reg + 1'b1;
			end
		end else if (pop_in) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				stack_next[i] = stack_reg[i+1];
			end
			stack_next[DEPTH-1] = '0;
			if (depth_reg != '0) begin
				depth_next = depth_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				stack_reg[i] <= '0;
			end
			depth_reg <= '0;
		end else begin
			stack_reg <= stack_next;
			depth_reg <= depth_next;
		end
	end

	assign top_out   = stack_reg[0];
	assign depth_out = depth_reg;

endmodule
`default_nettype wire

// >>> testbench/dsd_prog_store_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsd_prog_store_model (
	input  wire logic [11:0] addr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  data_out
);
	logic [7:0] byte_val;
	// Contents are a fixed pattern of the address
	assign byte_val = addr_in[7:0] ^ {addr_in[11:8], addr_in[11:8]} ^ 8'h5a;
	// Outside a window read the bus shows the inverse, not the last byte
	assign data_out = rd_in ? byte_val : ~byte_val;
endmodule
`default_nettype wire

// >>> testbench/data_space_decoder_rom_window_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module data_space_decoder_rom_window_tb_top;
	logic        clk_sys_in = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, prog_data;
	logic        rd = 1'b0, wr = 1'b0, bit_op = 1'b0;
	logic        pc_inc = 1'b0, pc_load = 1'b0, call_req = 1'b0;
	logic        ret_req = 1'b0, protect = 1'b0, ext_rd = 1'b0;
	logic [11:0] pc_target = 12'h000, ext_addr = 12'h000;
	logic [3:0]  region_out;
	logic        acc_rd_out, acc_wr_out, prog_win_rd_out, win_rvalid_out;
	logic [5:0]  acc_index_out;
	logic [7:0]  acc_wdata_out, win_rdata_out;
	logic [11:0] prog_win_addr_out, pc_out, ret_addr_out, prog_ext_addr_out;
	logic        sel_ram, sel_nv1, sel_nv0, prog_ext_rd_out, ext_blocked_out;
	logic [2:0]  stack_depth_out;
	int          n_errors = 0;
	int          cmp_count = 0;
	logic [5:0]  base_m;
	logic [7:0]  bank_m;
	int          pc_m;
	int          stk[$];
	logic [7:0]  wr_list [7] = '{8'h40, 8'hc3, 8'h84, 8'hc8, 8'hff, 8'hea,
		8'hcf};
	logic [7:0]  bank_vals [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h13};

	always #4 clk_sys_in = ~clk_sys_in;

	dsd_decoder dsd_decoder_inst (
		.clk_sys_in(clk_sys_in), .rst_in(rst), .addr_in(addr), .rd_in(rd),
		.wr_in(wr), .bit_op_in(bit_op), .wdata_in(wdata),
		.prog_data_in(prog_data), .pc_inc_in(pc_inc), .pc_load_in(pc_load),
		.pc_target_in(pc_target), .call_in(call_req), .ret_in(ret_req),
		.protect_opt_in(protect), .ext_rd_in(ext_rd), .ext_addr_in(ext_addr),
		.region_out(region_out), .acc_rd_out(acc_rd_out),
		.acc_wr_out(acc_wr_out), .acc_index_out(acc_index_out),
		.acc_wdata_out(acc_wdata_out), .prog_win_addr_out(prog_win_addr_out),
		.prog_win_rd_out(prog_win_rd_out), .win_rdata_out(win_rdata_out),
		.win_rvalid_out(win_rvalid_out), .extra_ram_page_sel_out(sel_ram),
		.nvm_page1_sel_out(sel_nv1), .nvm_page0_sel_out(sel_nv0),
		.pc_out(pc_out), .ret_addr_out(ret_addr_out),
		.stack_depth_out(stack_depth_out), .prog_ext_rd_out(prog_ext_rd_out),
		.prog_ext_addr_out(prog_ext_addr_out),
		.ext_blocked_out(ext_blocked_out)
	);

	dsd_prog_store_model dsd_prog_store_model_inst (
		.addr_in(prog_win_addr_out), .rd_in(prog_win_rd_out),
		.data_out(prog_data)
	);

	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask

	function automatic int exp_region(input logic [7:0] a, input logic w,
		input logic b);
		if (a <= 8'h3f) return 1;
		if (a <= 8'h7f) return w ? 0 : 2;
		if (a <= 8'h83) return 3;
		if (a <= 8'hbf) return 4;
		if (a <= 8'hc2) return 5;
		if (a >= 8'hc4 && a <= 8'hc6) return 6;
		if (a == 8'hc8) return w ? 7 : 0;
		if (a == 8'hc9) return (w && !b) ? 8 : 0;
		if (a >= 8'hcc && a <= 8'hce) return 9;
		if (a >= 8'hd2 && a <= 8'hd4) return 10;
		if (a >= 8'he0 && a <= 8'he2) return 11;
		if (a == 8'he8) return (w && !b) ? 12 : 0;
		if (a == 8'hea) return 13;
		if (a == 8'hff) return 14;
		return 0;
	endfunction

	function automatic int idx(input logic [7:0] a, input int r);
		case (r)
			1, 2: return int'(a[5:0]);
			3: return a - 8'h80;
			4: return a - 8'h84;
			5: return a - 8'hc0;
			6: return a - 8'hc4;
			9: return a - 8'hcc;
			10: return a - 8'hd2;
			11: return a - 8'he0;
			default: return int'(a[5:0]);
		endcase
	endfunction

	function automatic logic [7:0] pd(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
	endfunction

	task automatic chk_bank();
		chk_val({9'h000, sel_ram, sel_nv1, sel_nv0},
			{9'h000, bank_m[4], bank_m[1], bank_m[0]});
	endtask

	task automatic acc(input logic [7:0] a, input logic w, input logic b,
		input logic [7:0] d);
		int r;
		logic [11:0] wa;
		r = exp_region(a, w, b);
		wa = {base_m, a[5:0]};
		@(posedge clk_sys_in);
		addr <= a;
		rd <= !w;
		wr <= w;
		bit_op <= b;
		wdata <= d;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
		chk_val({8'h00, region_out}, 12'(r));
		chk_flag(acc_rd_out, !w && r != 0);
		chk_flag(acc_wr_out, w && r != 0);
		if (r != 0)
			chk_val({6'h00, acc_index_out}, 12'(idx(a, r)));
		if (w && r != 0)
			chk_val({4'h0, acc_wdata_out}, {4'h0, d});
		chk_flag(prog_win_rd_out, r == 2);
		if (r == 2) begin
			chk_val(prog_win_addr_out, wa);
			@(posedge clk_sys_in);
			#1;
			chk_flag(win_rvalid_out, 1'b1);
			chk_val({4'h0, win_rdata_out}, {4'h0, pd(wa)});
		end
		if (w && r == 8)
			base_m = d[5:0];
		if (w && r == 12)
			bank_m = d;
		chk_bank();
	endtask

	task automatic pc_op(input int k, input logic [11:0] t);
		@(posedge clk_sys_in);
		pc_inc <= k == 0;
		pc_load <= k == 1;
		call_req <= k == 2;
		ret_req <= k == 3;
		pc_target <= t;
		@(posedge clk_sys_in);
		{pc_inc, pc_load, call_req, ret_req} <= 4'h0;
		#1;
		case (k)
			0: pc_m = (pc_m + 1) % 4096;
			1: pc_m = t;
			2: begin
				if (stk.size() == 6)
					void'(stk.pop_front());
				stk.push_back(pc_m);
				pc_m = t;
			end
			default: pc_m = stk.size() ? stk.pop_back() : 0;
		endcase
		chk_val(pc_out, 12'(pc_m));
		chk_val(ret_addr_out, stk.size() ? 12'(stk[$]) : 12'h000);
		chk_val({9'h000, stack_depth_out}, 12'(stk.size()));
	endtask

	task automatic ext(input logic p, input logic [11:0] a);
		@(posedge clk_sys_in);
		protect <= p;
		ext_rd <= 1'b1;
		ext_addr <= a;
		@(posedge clk_sys_in);
		ext_rd <= 1'b0;
		#1;
		chk_flag(prog_ext_rd_out, !p);
		chk_flag(ext_blocked_out, p);
		if (!p)
			chk_val(prog_ext_addr_out, a);
	endtask

	task automatic do_reset();
		@(posedge clk_sys_in);
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rst <= 1'b0;
		#1;
		base_m = 6'h00;
		bank_m = 8'h00;
		pc_m = 0;
		stk.delete();
		chk_val(pc_out, 12'h000);
		chk_val({9'h000, stack_depth_out}, 12'h000);
		chk_bank();
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys_in);
		n_errors++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h8bf3de4a));
		do_reset();
		acc(8'h45, 1'b0, 1'b0, 8'h00);
		acc(8'h84, 1'b1, 1'b0, 8'hff);
		acc(8'hc9, 1'b1, 1'b0, 8'hff);
		acc(8'h7f, 1'b0, 1'b0, 8'h00);
		acc(8'hc9, 1'b1, 1'b1, 8'h05);
		acc(8'h40, 1'b0, 1'b0, 8'h00);
		acc(8'hc9, 1'b0, 1'b0, 8'h00);
		for (int a = 0; a < 256; a++)
			acc(8'(a), 1'b0, 1'b0, 8'h00);
		foreach (wr_list[i])
			acc(wr_list[i], 1'b1, 1'b0, 8'($urandom));
		foreach (bank_vals[i])
			acc(8'he8, 1'b1, 1'b0, bank_vals[i]);
		acc(8'he8, 1'b1, 1'b1, 8'h00);
		acc(8'he8, 1'b0, 1'b0, 8'h00);
		repeat (40) begin
			acc(8'hc9, 1'b1, 1'b0, 8'($urandom));
			acc(8'h40 + 8'($urandom % 64), 1'b0, 1'b0, 8'h00);
		end
		pc_op(1, 12'hffe);
		pc_op(0, 12'h000);
		pc_op(0, 12'h000);
		repeat (7) pc_op(2, 12'($urandom));
		repeat (7) pc_op(3, 12'h000);
		// Call followed at once by return
		@(posedge clk_sys_in);
		call_req <= 1'b1;
		pc_target <= 12'($urandom);
		@(posedge clk_sys_in);
		call_req <= 1'b0;
		ret_req <= 1'b1;
		@(posedge clk_sys_in);
		ret_req <= 1'b0;
		#1;
		chk_val(pc_out, 12'(pc_m));
		chk_val({9'h000, stack_depth_out}, 12'(stk.size()));
		chk_bank();
		ext(1'b0, 12'h123);
		ext(1'b1, 12'habc);
		ext(1'b0, 12'($urandom));
		do_reset();
		acc(8'h7f, 1'b0, 1'b0, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
